/* File: core/ocs_pkg.sv */
/*
  Shared constants, divider tables and helper functions for the output
  divider, clock stop and sync block and for the controller that loads
  the stop register.
  Assumes mclk stands in for the VCO clock at 25 MHz.
*/
package ocs_pkg;

  // Clock figures, in nanoseconds, and derived cycle counts.
  localparam int MCLK_PERIOD_NS = 40;
  localparam int LINK_PERIOD_NS = 160;
  localparam int LINK_HALF_CYC  = LINK_PERIOD_NS / (2 * MCLK_PERIOD_NS);
  localparam int LINK_DIV_W     = 4;
  localparam logic [LINK_DIV_W-1:0] LINK_HALF_LAST =
    LINK_DIV_W'(LINK_HALF_CYC - 1);

  // Stop register layout.
  localparam int STOP_BITS     = 12;
  localparam int FRAME_BITS    = 13;
  localparam int STOP_A_LSB    = 0;
  localparam int STOP_B_LSB    = 4;
  localparam int STOP_C_LSB    = 8;
  localparam int STOP_SYNC_BIT = 11;
  localparam logic [STOP_BITS-1:0] STOP_EN_RST = 12'hFFF;
  localparam logic [STOP_BITS-1:0] OUT_RST     = 12'h800;
  localparam logic [3:0] LAST_BIT_IDX  = 4'hB;
  localparam logic [3:0] FRAME_LEN     = 4'hD;

  // Select pin bundle layout.
  localparam int SEL_W        = 10;
  localparam int SEL_A_LSB    = 0;
  localparam int SEL_B_LSB    = 2;
  localparam int SEL_C_LSB    = 4;
  localparam int SEL_FB_LSB   = 6;
  localparam int SEL_POST_BIT = 9;

  // Divider tables at post-divide by one; index is the select code.
  localparam logic [3:0][4:0] BASE_A = {5'h0C, 5'h08, 5'h06, 5'h04};
  localparam logic [3:0][4:0] BASE_B = {5'h0A, 5'h08, 5'h06, 5'h04};
  localparam logic [3:0][4:0] BASE_C = {5'h08, 5'h06, 5'h04, 5'h02};
  localparam logic [7:0][4:0] BASE_FB =
    {5'h14, 5'h14, 5'h10, 5'h0C, 5'h0A, 5'h08, 5'h06, 5'h04};

  localparam int CNT_W = 6;
  localparam logic [CNT_W-1:0] CNT_RST = 6'h3F;

  // Whole divide ratio in mclk cycles: post-divider times bank divider.
  function automatic logic [CNT_W-1:0] period_of(input logic post2,
                                                 input logic [4:0] base);
    return post2 ? {base, 1'b0} : {1'b0, base};
  endfunction : period_of

  // Free-running modulo counter step; a shrunk period wraps at once.
  function automatic logic [CNT_W-1:0] step(input logic [CNT_W-1:0] cnt,
                                            input logic [CNT_W-1:0] p);
    return (cnt >= p - 6'h01) ? 6'h00 : cnt + 6'h01;
  endfunction : step

  // Least common multiple of two periods, small enough to fit CNT_W.
  function automatic logic [CNT_W-1:0] lcm_of(input logic [CNT_W-1:0] a,
                                              input logic [CNT_W-1:0] b);
    int m;
    logic [CNT_W-1:0] r;
    r = a;
    for (int k = 12; k >= 1; k--) begin
      m = int'(a) * k;
      if ((m % int'(b)) == 0 && m < 64) begin
        r = CNT_W'(m);
      end
    end
    return r;
  endfunction : lcm_of

endpackage : ocs_pkg

/* File: core/ocs_stop_if.sv */
/*
  Serial clock-stop link between the controller and the clock device.
  Assumes the controller makes the stop clock and the device only
  listens; both wires are driven from controller flip-flops.
*/
`timescale 1ns/1ps
interface ocs_stop_if;
  logic stop_clk;
  logic stop_data;

  modport device (
    input stop_clk,
    input stop_data
  );

  modport ctrl (
    output stop_clk,
    output stop_data
  );
endinterface : ocs_stop_if

/* File: core/ocs_ctrl.sv */
/*
  Controller end of the clock-stop link: divides mclk into a free-running
  stop clock and shifts a start bit plus twelve enable bits on request.
  Assumes the user raises load only while busy is low, or accepts that a
  load during busy is ignored.
*/
`timescale 1ns/1ps
module ocs_ctrl
  import ocs_pkg::*;
(
  // Clock and reset
  input  wire logic                 mclk,
  input  wire logic                 rst_n,
  // Link
  ocs_stop_if.ctrl                  link,
  // User side
  input  wire logic                 load,
  input  wire logic [STOP_BITS-1:0] enables,
  output logic                      busy
);

  typedef struct packed {
    logic [LINK_DIV_W-1:0] div;
    logic                  clk;
    logic                  data;
    logic                  busy;
    logic [3:0]            left;
    logic [FRAME_BITS-1:0] frame;
  } ocs_ctrl_st_t;

  ocs_ctrl_st_t r;
  ocs_ctrl_st_t n;
  logic         tick;
  logic         fall;

  always_comb begin
    n    = r;
    tick = (r.div == LINK_HALF_LAST);
    fall = tick && r.clk;
    // The clock never pauses, even between frames. [RQ13]
    n.div = tick ? '0 : r.div + 1'b1;
    if (tick) begin
      n.clk = ~r.clk;
    end
    if (load && !r.busy) begin
      n.busy  = 1'b1;
      n.left  = FRAME_LEN;
      n.frame = {1'b0, enables}; // [RQ12]
    end else if (fall && r.busy) begin
      // Data moves on the falling edge, a half period clear of the
      // device's rising sampling edge. [RQ14]
      if (r.left != 4'h0) begin
        n.data  = r.frame[FRAME_BITS-1]; // [RQ13]
        n.frame = {r.frame[FRAME_BITS-2:0], 1'b1};
        n.left  = r.left - 4'h1;
      end else begin
        n.data = 1'b1;
        n.busy = 1'b0;
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      r <= '{div: '0, clk: 1'b0, data: 1'b1, busy: 1'b0, left: 4'h0,
             frame: '1};
    end else begin
      r <= n;
    end
  end

  assign link.stop_clk  = r.clk;
  assign link.stop_data = r.data;
  assign busy           = r.busy;

endmodule : ocs_ctrl

/* File: core/ocs_device.sv */
/*
  Digital side of the clock generator: reference selection, feedback and
  bank dividers, the serial stop register on the link clock, runt-free
  output gating and the coincidence pulse.
  Assumes mclk stands in for the VCO output and the select pins may
  change at any time relative to it. rst_n models the power-on reset.
*/
`timescale 1ns/1ps

// Functional notes
// RQ1 - Reference comes from one of three sources.
// RQ2 - Bank output is VCO over post times bank.
// RQ3 - Post-divider is one or two, ratio unchanged.
// RQ4 - Feedback divider chosen by three select bits.
// RQ5 - Each bank has its own two-bit divider.
// RQ6 - Configurer keeps the VCO within range.
// RQ7 - Twelve-bit serially loaded stop register.
// RQ8 - First bank C and feedback never stop.
// RQ9 - Enable zero holds output low.
// RQ10 - Enable one lets output run.
// RQ11 - Switch only while output is low.
// RQ12 - Zero start bit then twelve data bits.
// RQ13 - Stop clock free-running, one bit per period.
// RQ14 - Data sampled on stop clock rising edge.
// RQ15 - Sync low one period before coincident rise.
// RQ16 - Sync width is the faster bank period.
// RQ17 - Sync works for every divider combination.
// RQ18 - All enables are one after reset.
// RQ19 - Apply only full frames, ignore until start.
module ocs_device
  import ocs_pkg::*;
(
  // Clock and reset
  input  wire logic       mclk,
  input  wire logic       rst_n,
  // Stop link
  ocs_stop_if.device      link,
  // Reference selection
  input  wire logic       reference_input_zero,
  input  wire logic       reference_input_one,
  input  wire logic       xtal_clk,
  input  wire logic       reference_input_choice,
  input  wire logic       ref_use_xtal,
  output logic            reference_out,
  // Divider selects
  input  wire logic [2:0] feedback_divider_select,
  input  wire logic [1:0] bank_a_divider_select,
  input  wire logic [1:0] bank_b_divider_select,
  input  wire logic [1:0] bank_c_divider_select,
  input  wire logic       post_divide_select,
  // Clock outputs
  output logic [3:0]      bank_a_outputs,
  output logic [3:0]      bank_b_outputs,
  output logic [3:0]      bank_c_outputs,
  output logic            loop_return_output,
  output logic            coincidence_pulse_out
);

  // Link-clock domain state.
  typedef struct packed {
    logic                 busy;
    logic [3:0]           cnt;
    logic [STOP_BITS-1:0] shift;
    logic [STOP_BITS-1:0] word;
    logic                 tog;
  } ocs_link_st_t;

  // Core-clock domain state.
  typedef struct packed {
    logic [SEL_W-1:0]     sel_s1;
    logic [SEL_W-1:0]     sel_s2;
    logic [SEL_W-1:0]     sel_s3;
    logic [SEL_W-1:0]     sel_q;
    logic                 tog_s1;
    logic                 tog_s2;
    logic                 tog_s3;
    logic                 tog_q;
    logic [STOP_BITS-1:0] pend;
    logic [STOP_BITS-1:0] en;
    logic [CNT_W-1:0]     cnt_a;
    logic [CNT_W-1:0]     cnt_b;
    logic [CNT_W-1:0]     cnt_c;
    logic [CNT_W-1:0]     cnt_f;
    logic [CNT_W-1:0]     cnt_s;
    logic [STOP_BITS-1:0] out;
    logic                 c0;
    logic                 fb;
  } ocs_core_st_t;

  ocs_link_st_t     lr;
  ocs_link_st_t     ln;
  ocs_core_st_t     r;
  ocs_core_st_t     n;
  logic [SEL_W-1:0] sel_pins;
  logic             post2;
  logic [CNT_W-1:0] pa;
  logic [CNT_W-1:0] pb;
  logic [CNT_W-1:0] pc;
  logic [CNT_W-1:0] pf;
  logic [CNT_W-1:0] pl;
  logic [CNT_W-1:0] pfast;
  logic             wrap_a;
  logic             wrap_c;
  logic [STOP_BITS-1:0] raw;

  // The reference is a clock, so it goes through a plain mux; a flop
  // here would halve its usable rate. [RQ1]
  assign reference_out = ref_use_xtal ? xtal_clk :
                         (reference_input_choice ? reference_input_one
                                                 : reference_input_zero);

  assign sel_pins = {post_divide_select, feedback_divider_select,
                     bank_c_divider_select, bank_b_divider_select,
                     bank_a_divider_select};

  // Serial receiver on the stop clock.
  always_comb begin
    ln = lr;
    if (!lr.busy) begin
      // Only a zero on an idle line opens a frame. [RQ12] [RQ19]
      if (!link.stop_data) begin
        ln.busy = 1'b1;
        ln.cnt  = 4'h0;
      end
    end else begin
      // One bit per rising edge, first bit ends up in the top bit.
      ln.shift = {lr.shift[STOP_BITS-2:0], link.stop_data}; // [RQ14] [RQ7]
      ln.cnt   = lr.cnt + 4'h1;
      if (lr.cnt == LAST_BIT_IDX) begin
        // The word is published only when all twelve bits are in. [RQ19]
        ln.word = {lr.shift[STOP_BITS-2:0], link.stop_data};
        ln.tog  = ~lr.tog;
        ln.busy = 1'b0;
      end
    end
  end

  always_ff @(posedge link.stop_clk or negedge rst_n) begin
    if (!rst_n) begin
      lr <= '{busy: 1'b0, cnt: 4'h0, shift: STOP_EN_RST,
              word: STOP_EN_RST, tog: 1'b0};
    end else begin
      lr <= ln;
    end
  end

  always_comb begin
    n = r;
    // Select pins are asynchronous; a bit only counts once stages two
    // and three agree, so a pin caught mid-change is not taken.
    n.sel_s1 = sel_pins;
    n.sel_s2 = r.sel_s1;
    n.sel_s3 = r.sel_s2;
    n.sel_q  = (r.sel_s2 & r.sel_s3) | (r.sel_q & (r.sel_s2 ^ r.sel_s3));

    post2 = r.sel_q[SEL_POST_BIT];
    // The post-divider scales every bank and the feedback alike, so the
    // output to reference ratio is untouched. [RQ3]
    pa = period_of(post2, BASE_A[r.sel_q[SEL_A_LSB +: 2]]);   // [RQ5]
    pb = period_of(post2, BASE_B[r.sel_q[SEL_B_LSB +: 2]]);   // [RQ5]
    pc = period_of(post2, BASE_C[r.sel_q[SEL_C_LSB +: 2]]);   // [RQ5]
    pf = period_of(post2, BASE_FB[r.sel_q[SEL_FB_LSB +: 3]]); // [RQ4]
    pl    = lcm_of(pa, pc);                                   // [RQ17]
    pfast = (pa < pc) ? pa : pc;                              // [RQ16]

    // Every divide ratio is even, so high for half a period is 50 %.
    n.cnt_a = step(r.cnt_a, pa); // [RQ2]
    n.cnt_b = step(r.cnt_b, pb); // [RQ2]
    n.cnt_c = step(r.cnt_c, pc); // [RQ2]
    n.cnt_f = step(r.cnt_f, pf); // [RQ4]
    wrap_a  = (n.cnt_a == 6'h00);
    wrap_c  = (n.cnt_c == 6'h00);
    // A common rise of A and C restarts the sync count, which also
    // realigns it after a divider change. [RQ15] [RQ17]
    n.cnt_s = (wrap_a && wrap_c) ? 6'h00 : step(r.cnt_s, pl);
    // A newly taken select restarts every divider together, so A and C
    // keep common rising edges once the selects settle. All outputs sit
    // low for that one cycle, so a high phase in flight is cut short;
    // select changes carry no glitch promise. [RQ17]
    if (n.sel_q != r.sel_q) begin
      n.cnt_a = CNT_RST;
      n.cnt_b = CNT_RST;
      n.cnt_c = CNT_RST;
      n.cnt_f = CNT_RST;
      n.cnt_s = CNT_RST;
    end

    raw = '0;
    raw[STOP_A_LSB +: 4] = {4{n.cnt_a < (pa >> 1)}};
    raw[STOP_B_LSB +: 4] = {4{n.cnt_b < (pb >> 1)}};
    raw[STOP_C_LSB +: 3] = {3{n.cnt_c < (pc >> 1)}};
    // Low for the last fast period before the common rise. [RQ15] [RQ16]
    raw[STOP_SYNC_BIT] = !(n.cnt_s >= pl - pfast);

    // Frame-done toggle crosses with three stages; the word itself is
    // held still for a whole frame, so it is safe to copy on the event.
    n.tog_s1 = lr.tog;
    n.tog_s2 = r.tog_s1;
    n.tog_s3 = r.tog_s2;
    n.tog_q  = (r.tog_s2 == r.tog_s3) ? r.tog_s3 : r.tog_q;
    if (n.tog_q != r.tog_q) begin
      n.pend = lr.word; // [RQ19]
    end

    // An enable only moves while its output sits low. [RQ11]
    n.en  = (raw & r.en) | (~raw & r.pend);
    // Zero holds low, one passes the divided clock. [RQ9] [RQ10]
    n.out = raw & n.en;
    // These two have no enable bit at all. [RQ8]
    n.c0  = n.cnt_c < (pc >> 1);
    n.fb  = n.cnt_f < (pf >> 1);
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      r <= '{sel_s1: '0, sel_s2: '0, sel_s3: '0, sel_q: '0,
             tog_s1: 1'b0, tog_s2: 1'b0, tog_s3: 1'b0, tog_q: 1'b0,
             pend: STOP_EN_RST, en: STOP_EN_RST, // [RQ18]
             cnt_a: CNT_RST, cnt_b: CNT_RST, cnt_c: CNT_RST,
             cnt_f: CNT_RST, cnt_s: CNT_RST,
             out: OUT_RST, c0: 1'b0, fb: 1'b0};
    end else begin
      r <= n;
    end
  end

  assign bank_a_outputs        = r.out[STOP_A_LSB +: 4];
  assign bank_b_outputs        = r.out[STOP_B_LSB +: 4];
  assign bank_c_outputs        = {r.out[STOP_C_LSB +: 3], r.c0}; // [RQ8]
  assign loop_return_output    = r.fb;
  assign coincidence_pulse_out = r.out[STOP_SYNC_BIT];

endmodule : ocs_device

/* File: bench/ocs_checker.sv */
/*
  Link and output checker for the clock-stop block.
  Assumes the divider selects change only while rst_n is low.
*/
`timescale 1ns/1ps
module ocs_checker (
  // Clock and reset
  input wire logic       mclk,
  input wire logic       rst_n,
  // Link and outputs
  input wire logic       stop_clk,
  input wire logic       stop_data,
  input wire logic [3:0] bank_a_outputs,
  input wire logic [3:0] bank_c_outputs,
  input wire logic       loop_return_output,
  input wire logic       coincidence_pulse_out
);
  logic [3:0] pos_r;
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  // Frame position: one for the start bit, thirteen for the last bit.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) pos_r <= 4'h0;
    else if (pos_r == 4'h0 && $fell(stop_data)) pos_r <= 4'h1;
    else if (pos_r != 4'h0 && $fell(stop_clk))
      pos_r <= (pos_r == 4'hD) ? 4'h0 : pos_r + 4'h1;
  end
  sequence s_start;
    pos_r == 4'h0 && $fell(stop_data);
  endsequence
  sequence s_back_idle;
    ##53 (pos_r == 4'h0 && stop_data);
  endsequence
  property p_frame; s_start |-> s_back_idle; endproperty
  property p_clk_period;
    $changed(stop_clk) |=> !$changed(stop_clk) ##1 $changed(stop_clk);
  endproperty
  property p_data_edge; $changed(stop_data) |-> $fell(stop_clk); endproperty
  property p_bit_hold;
    $changed(stop_data) |=> $stable(stop_data)[*3];
  endproperty
  property p_c0_runs;
    $fell(bank_c_outputs[0]) |-> ##[1:8] $rose(bank_c_outputs[0]);
  endproperty
  property p_fb_runs;
    $fell(loop_return_output) |-> ##[1:20] $rose(loop_return_output);
  endproperty
  property p_sync_end;
    $rose(coincidence_pulse_out) |-> $rose(bank_c_outputs[0]);
  endproperty
  property p_sync_width;
    $fell(coincidence_pulse_out) |=> !coincidence_pulse_out;
  endproperty
  property p_no_runt;
    $rose(bank_a_outputs[1]) |=> bank_a_outputs[1];
  endproperty
  a_frame: assert property (p_frame)
    else $error("frame length wrong");
  a_clk_period: assert property (p_clk_period)
    else $error("stop clock period wrong");
  a_data_edge: assert property (p_data_edge)
    else $error("data moved off falling stop clock");
  a_bit_hold: assert property (p_bit_hold)
    else $error("data bit too short");
  a_c0_runs: assert property (p_c0_runs)
    else $error("first bank C output stopped");
  a_fb_runs: assert property (p_fb_runs)
    else $error("loop return output stopped");
  a_sync_end: assert property (p_sync_end)
    else $error("sync pulse not ending at common rise");
  a_sync_width: assert property (p_sync_width)
    else $error("sync pulse too short");
  a_no_runt: assert property (p_no_runt)
    else $error("runt pulse on bank A");
endmodule : ocs_checker

/* File: bench/tb_output_divider_clock_stop_sync.sv */
/*
  Testbench joining controller and device over the stop link.
  Assumes selects are only changed under reset, so periods are clean.
*/
`timescale 1ns/1ps
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin \
  bad_count++; $display("BAD %0t value mismatch", $time); end end
module tb_output_divider_clock_stop_sync;
  import ocs_pkg::*;
  logic mclk, rst_n, load, busy, r0, r1, xt, ch, ux, ref_o, post, qf;
  logic sync_n, c0;
  logic [11:0] en, e, seen;
  logic [2:0] fb_s;
  logic [1:0] a_s, b_s, c_s;
  logic [3:0] qa, qb, qc;
  logic [5:0] mon, mon_d;
  logic [11:0] eq[$];
  int bad_count, checks_done, seed, p, n, m, pa, pc;
  int ta[4] = '{4, 6, 8, 12};
  int tb[4] = '{4, 6, 8, 10};
  int tc[4] = '{2, 4, 6, 8};
  int tf[8] = '{4, 6, 8, 10, 12, 16, 20, 20};
  ocs_stop_if link_if();
  ocs_ctrl ocs_ctrl_inst (.mclk(mclk), .rst_n(rst_n), .link(link_if),
    .load(load), .enables(en), .busy(busy));
  ocs_device ocs_device_inst (.mclk(mclk), .rst_n(rst_n), .link(link_if),
    .reference_input_zero(r0), .reference_input_one(r1), .xtal_clk(xt),
    .reference_input_choice(ch), .ref_use_xtal(ux), .reference_out(ref_o),
    .feedback_divider_select(fb_s), .bank_a_divider_select(a_s),
    .bank_b_divider_select(b_s), .bank_c_divider_select(c_s),
    .post_divide_select(post), .bank_a_outputs(qa), .bank_b_outputs(qb),
    .bank_c_outputs(qc), .loop_return_output(qf),
    .coincidence_pulse_out(sync_n));
  ocs_checker ocs_checker_inst (.mclk(mclk), .rst_n(rst_n),
    .stop_clk(link_if.stop_clk), .stop_data(link_if.stop_data),
    .bank_a_outputs(qa), .bank_c_outputs(qc), .loop_return_output(qf),
    .coincidence_pulse_out(sync_n));
  assign mon = {~sync_n, sync_n, qf, qc[0], qb[0], qa[0]};
  always #20 mclk = ~mclk;
  always @(posedge mclk) mon_d <= mon;
  function automatic int lcm_i(int a, int b);
    int x;
    x = a;
    while (x % b != 0) x += a;
    return x;
  endfunction : lcm_i
  task automatic give_verdict;
    $display("checks %0d bad %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : give_verdict
  // Cycles until the next rising edge of monitored bit k.
  task automatic wait_rise(input int k, output int c);
    c = 0;
    do begin
      @(posedge mclk);
      #1;
      c++;
    end while (!(mon[k] && !mon_d[k]) && c < 200);
  endtask : wait_rise
  task automatic send(input logic [11:0] v);
    int c;
    @(negedge mclk);
    en = v;
    load = 1'b1;
    @(negedge mclk);
    load = 1'b0;
    repeat (2) @(negedge mclk);
    c = 0;
    while (busy !== 1'b0 && c < 200) begin
      @(negedge mclk);
      c++;
    end
    if (busy !== 1'b0) begin
      bad_count++;
      $display("BAD %0t link stayed busy", $time);
    end
    eq.push_back(v);
  endtask : send
  initial begin
    #2000000;
    bad_count++;
    give_verdict;
  end
  initial begin
    mclk = 0; rst_n = 0; load = 0; en = 12'hFFF; seed = 32'h6eb65fe5;
    {r0, r1, xt, ch, ux, post} = 6'h00; fb_s = 3'h0;
    {a_s, b_s, c_s} = 6'h00; bad_count = 0; checks_done = 0;
    repeat (16) @(negedge mclk);
    for (int i = 0; i < 8; i++) begin
      rst_n = 1'b0;
      {post, fb_s, a_s, b_s, c_s} = 10'($random(seed));
      // Codes six and seven are not a feedback choice at post one.
      if (!post && fb_s > 3'h5) fb_s = fb_s - 3'h2;
      repeat (16) @(negedge mclk);
      rst_n = 1'b1;
      @(posedge mclk);
      #1;
      `CHK({qa, qb, qc, qf, sync_n}, 14'h3FFF)
      m = post ? 2 : 1;
      pa = m * ta[a_s];
      pc = m * tc[c_s];
      wait_rise(0, n); wait_rise(0, p);
      `CHK(p, pa)
      wait_rise(1, n); wait_rise(1, p);
      `CHK(p, m * tb[b_s])
      wait_rise(2, n); wait_rise(2, p);
      `CHK(p, pc)
      wait_rise(3, n); wait_rise(3, p);
      `CHK(p, m * tf[fb_s])
      if (pa != pc) begin
        wait_rise(5, n); wait_rise(4, p);
        `CHK(p, (pa < pc) ? pa : pc)
        wait_rise(4, p);
        `CHK(p, lcm_i(pa, pc))
      end else begin
        // Every rise is a common one, so the pulses merge into a level.
        c0 = 1'b0;
        repeat (2 * pa) begin
          @(posedge mclk);
          #1;
          c0 = c0 | sync_n;
        end
        `CHK(c0, 1'b0)
      end
      @(negedge mclk);
      {r0, r1, xt, ch, ux} = 5'($random(seed));
      #1;
      `CHK(ref_o, ux ? xt : (ch ? r1 : r0))
      @(negedge mclk);
    end
    for (int i = 0; i < 6; i++) begin
      e = (i == 0) ? 12'h000 : (i == 1) ? 12'hFFF : 12'($random(seed));
      // Two frames back to back: only the second may stay in force.
      send(~e);
      send(e);
      repeat (64) @(posedge mclk);
      seen = 12'h000;
      c0 = 1'b0;
      repeat (64) begin
        @(posedge mclk);
        #1;
        seen = seen | {sync_n, qc[3:1], qb, qa};
        c0 = c0 | qc[0];
      end
      // With equal A and C periods the sync never shows a high level.
      `CHK(seen, eq[$] & {(pa != pc), 11'h7FF})
      `CHK(c0, 1'b1)
      eq.delete();
    end
    give_verdict;
  end
endmodule : tb_output_divider_clock_stop_sync
